// [hdl/stp_pkg.sv]
// stp_pkg: constants shared by the timer prescaler design
// assumes a 25 MHz system clock and a word-addressed Avalon-MM slave
package stp_pkg;

    // system clock period, for reference
    localparam int CLK_PERIOD_NS = 40;

    // register word indices
    localparam logic [7:0] GTC_IDX  = 8'h43;
    localparam logic [7:0] CSEL_IDX = 8'h50;
    localparam logic [7:0] STAT_IDX = 8'h51;

    // general_timer_control fields
    localparam int         GTC_HOLD_BIT  = 7;
    localparam int         GTC_ASYNC_BIT = 1;
    localparam int         GTC_SYNC_BIT  = 0;
    localparam logic [7:0] GTC_RESET     = 8'h00;

    // timer clock select register layout
    localparam int         CSEL_W     = 3;
    localparam int         CSEL0_LSB  = 0;
    localparam int         CSEL1_LSB  = 4;
    localparam logic [2:0] CSEL_RESET = 3'h0;

    // status register layout
    localparam int STAT_HOLD_BIT = 16;

    // shared divider and its taps (divide by 8, 64, 256, 1024)
    localparam int DIV_W = 10;
    localparam int NTAP  = 4;
    localparam logic [DIV_W-1:0] TAP_MASK [NTAP] =
        '{10'h007, 10'h03F, 10'h0FF, 10'h3FF};
    localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;

    // clock select codes
    localparam logic [2:0] CS_STOP      = 3'h0;
    localparam logic [2:0] CS_DIRECT    = 3'h1;
    localparam logic [2:0] CS_TAP8      = 3'h2;
    localparam logic [2:0] CS_TAP64     = 3'h3;
    localparam logic [2:0] CS_TAP256    = 3'h4;
    localparam logic [2:0] CS_TAP1024   = 3'h5;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;

    // number of timers fed by the prescaler
    localparam int NTIMER = 2;

endpackage

// [hdl/stp_tap_if.sv]
// stp_tap_if: divider taps and halt from the prescaler to each selector
// assumes one source and any number of sinks on the same clock
`timescale 1ns/1ps
`default_nettype none
interface stp_tap_if
    import stp_pkg::*;
();
    logic [NTAP-1:0] tap;
    logic            halt;

    modport src  (output tap, output halt);
    modport sink (input  tap, input  halt);
endinterface
`default_nettype wire

// [hdl/stp_clock_select.sv]
// stp_clock_select: per-timer source selection and count pin edge detect
// assumes taps and halt come from the shared prescaler on the same clock
`timescale 1ns/1ps
`default_nettype none
module stp_clock_select
    import stp_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // shared divider taps
    stp_tap_if.sink                taps,
    // source selection for this timer
    input  wire logic [CSEL_W-1:0] clock_select_field,
    // external count pin, asynchronous
    input  wire logic              ext_count_pin,
    // one-cycle count enable to the timer
    output logic                   timer_count_clock
);
    logic       pin_latch;
    logic       pin_s1;
    logic       pin_s2;
    logic       rise;
    logic       fall;
    logic [1:0] tap_idx;
    logic       next_count;

    // pin latch, open while the clock is high
    always_latch
    begin
        if (!rst_b)
            pin_latch <= 1'b0;
        else if (clk)
            pin_latch <= ext_count_pin;
    end

    // two rising-edge registers behind the latch
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end
        else
        begin
            pin_s1 <= pin_latch;
            pin_s2 <= pin_s1;
        end
    end

    // edge detector runs whatever the selection, so history is kept
    assign rise    = pin_s1 & ~pin_s2;
    assign fall    = ~pin_s1 & pin_s2;
    assign tap_idx = 2'(clock_select_field - CS_TAP8);

    // source decode
    always_comb
    begin
        unique case (clock_select_field)
            CS_STOP:     next_count = 1'b0;
            CS_DIRECT:   next_count = ~taps.halt;
            CS_TAP8,
            CS_TAP64,
            CS_TAP256,
            CS_TAP1024:  next_count = taps.tap[tap_idx];
            CS_EXT_FALL: next_count = fall;
            CS_EXT_RISE: next_count = rise;
        endcase
    end

    // registered count enable, sets the pin-to-count delay
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            timer_count_clock <= 1'b0;
        else
            timer_count_clock <= next_count;
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    chk_direct_every: assert property (@(posedge clk) disable iff (!rst_b)
        (clock_select_field == CS_DIRECT && !taps.halt) |=> timer_count_clock)
        else $error("undivided source missed a cycle");
    chk_ext_rise: assert property (@(posedge clk) disable iff (!rst_b)
        (clock_select_field == CS_EXT_RISE) |=> (timer_count_clock == $past(rise)))
        else $error("rising edge count mismatch");
    chk_ext_fall: assert property (@(posedge clk) disable iff (!rst_b)
        (clock_select_field == CS_EXT_FALL) |=> (timer_count_clock == $past(fall)))
        else $error("falling edge count mismatch");
    chk_stop_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (clock_select_field == CS_STOP) |=> !timer_count_clock)
        else $error("stopped timer got a count");
    cov_ext_rise: cover property (@(posedge clk) disable iff (!rst_b)
        clock_select_field == CS_EXT_RISE && timer_count_clock);
endmodule
`default_nettype wire

// [hdl/stp_shared_prescaler.sv]
// stp_shared_prescaler: shared divider, control register, two timer sources
// assumes a word-addressed Avalon-MM master and asynchronous count pins
//
// Overview of operation
// - select 1 counts every system clock except under a prescaler reset
// - taps divide by 8, 64, 256, 1024
// - divider free running, shared by both timers
// - first prescaled count within 1 to N+1
// - divider reset restarts period for both timers
// - pin sampled each clock via latch, registers
// - one pulse per rising or falling edge
// - pin edge to count in 2.5-3.5 cycles
// - external clock is never prescaled
// - hold mode keeps written reset bits asserted
// - clearing hold clears both reset bits
// - bit 0 resets divider, self-clearing unless hold
// - select decode: stop, direct, taps, edges
// - pin counts even when driven as output
`timescale 1ns/1ps
`default_nettype none
module stp_shared_prescaler
    import stp_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // avalon-mm slave, word addressed
    input  wire logic [7:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    // external count pins, one per timer
    input  wire logic [NTIMER-1:0] ext_count_pin,
    // count enables to the timers
    output logic      [NTIMER-1:0] timer_count_clock,
    // control levels for the neighbouring timers
    output logic                   timer_sync_hold,
    output logic                   sync_prescaler_reset,
    output logic                   async_prescaler_reset
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic                   ack;
    logic                   wr_gtc;
    logic                   wr_csel;
    logic                   rd_take;
    logic [31:0]            next_readdata;
    logic [DIV_W-1:0]       div_cnt;
    logic [CSEL_W-1:0]      csel [NTIMER];
    logic [7:0]             gtc_view;
    stp_tap_if              taps ();

    ////////////////////////////////////////////////////////////////////
    // bus slave

    // one wait state on every access
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ack <= 1'b0;
        else
            ack <= (read | write) & ~ack;
    end

    assign waitrequest = (read | write) & ~ack;

    // write strobes, taken at the edge where waitrequest is low
    assign wr_gtc  = write & ack & (address == GTC_IDX) & byteenable[0];
    assign wr_csel = write & ack & (address == CSEL_IDX) & byteenable[0];
    assign rd_take = read & ~ack;

    // readable view of the control register
    always_comb
    begin
        gtc_view                = GTC_RESET;
        gtc_view[GTC_HOLD_BIT]  = timer_sync_hold;
        gtc_view[GTC_ASYNC_BIT] = async_prescaler_reset;
        gtc_view[GTC_SYNC_BIT]  = sync_prescaler_reset;
    end

    // read mux, unmapped words read as zero
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        unique case (address)
            GTC_IDX:
                next_readdata[7:0] = gtc_view;
            CSEL_IDX:
            begin
                next_readdata[CSEL0_LSB +: CSEL_W] = csel[0];
                next_readdata[CSEL1_LSB +: CSEL_W] = csel[1];
            end
            STAT_IDX:
            begin
                next_readdata[DIV_W-1:0]     = div_cnt;
                next_readdata[STAT_HOLD_BIT] = taps.halt;
            end
            default:
                next_readdata = 32'h0000_0000;
        endcase
    end

    // read data registered, stands when waitrequest drops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            readdata <= 32'h0000_0000;
        else if (rd_take)
            readdata <= next_readdata;
    end

    ////////////////////////////////////////////////////////////////////
    // control register

    // hold bit and prescaler reset bits
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer_sync_hold       <= 1'b0;
            sync_prescaler_reset  <= 1'b0;
            async_prescaler_reset <= 1'b0;
        end
        else if (wr_gtc)
        begin
            timer_sync_hold       <= writedata[GTC_HOLD_BIT];
            // written value kept while hold is one, cleared with it
            sync_prescaler_reset  <= writedata[GTC_SYNC_BIT];
            async_prescaler_reset <= writedata[GTC_ASYNC_BIT];
        end
        else if (!timer_sync_hold)
        begin
            // strobe drops one cycle after it was written
            sync_prescaler_reset  <= 1'b0;
            async_prescaler_reset <= 1'b0;
        end
    end

    // per-timer clock select fields
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            csel[0] <= CSEL_RESET;
            csel[1] <= CSEL_RESET;
        end
        else if (wr_csel)
        begin
            csel[0] <= writedata[CSEL0_LSB +: CSEL_W];
            csel[1] <= writedata[CSEL1_LSB +: CSEL_W];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared divider

    // free running, only the prescaler reset touches it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt <= DIV_RESET;
        else if (sync_prescaler_reset)
            div_cnt <= DIV_RESET;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // one-cycle tap pulses, once per divisor period
    generate
        for (genvar i = 0; i < NTAP; i++)
        begin : g_tap
            assign taps.tap[i] = ~sync_prescaler_reset &
                ((div_cnt & TAP_MASK[i]) == TAP_MASK[i]);
        end
    endgenerate

    // held reset halts the internal sources of both timers
    assign taps.halt = sync_prescaler_reset;

    ////////////////////////////////////////////////////////////////////
    // per-timer source selection

    generate
        for (genvar t = 0; t < NTIMER; t++)
        begin : g_timer
            stp_clock_select u_sel (
                .clk                (clk),
                .rst_b              (rst_b),
                .taps               (taps),
                .clock_select_field (csel[t]),
                .ext_count_pin      (ext_count_pin[t]),
                .timer_count_clock  (timer_count_clock[t])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // checks

    // a strobe written without hold lasts exactly one cycle
    chk_sync_strobe: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_gtc && writedata[GTC_SYNC_BIT] && !writedata[GTC_HOLD_BIT])
        |=> sync_prescaler_reset ##1 !sync_prescaler_reset)
        else $error("prescaler reset strobe not one cycle");

    // under hold the reset bits keep their value until the next write
    chk_hold_keeps: assert property (@(posedge clk) disable iff (!rst_b)
        (timer_sync_hold && !wr_gtc)
        |=> ($stable(sync_prescaler_reset) && $stable(async_prescaler_reset)))
        else $error("held reset bit changed without a write");

    // clearing hold clears both reset bits one cycle later
    chk_hold_release: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_gtc && writedata[7:0] == GTC_RESET)
        |=> (!sync_prescaler_reset && !async_prescaler_reset && !timer_sync_hold))
        else $error("hold release left a reset bit set");

    // divider sits at zero while reset, restarts from zero after
    chk_div_zero: assert property (@(posedge clk) disable iff (!rst_b)
        sync_prescaler_reset |=> (div_cnt == DIV_RESET))
        else $error("divider not cleared by prescaler reset");

    // first divide-by-8 pulse is the eighth cycle after release
    chk_first_tap: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(sync_prescaler_reset) |-> !taps.tap[0] [*7] ##1 taps.tap[0])
        else $error("first tap after reset at wrong cycle");

    // divide-by-8 pulses repeat every eight cycles when undisturbed
    chk_tap8_period: assert property (@(posedge clk)
        disable iff (!rst_b || sync_prescaler_reset)
        taps.tap[0] |=> !taps.tap[0] [*7] ##1 taps.tap[0])
        else $error("divide-by-8 period wrong");

    // larger taps only fire together with the smaller ones
    chk_tap_nested: assert property (@(posedge clk) disable iff (!rst_b)
        (taps.tap[3] |-> taps.tap[2]) and (taps.tap[2] |-> taps.tap[1])
        and (taps.tap[1] |-> taps.tap[0]))
        else $error("tap pulses out of step");

    // unused control bits read back as zero
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (read && ack && address == GTC_IDX) |-> (readdata[6:2] == 5'h00))
        else $error("reserved control bits not zero");

    // every access waits exactly one cycle
    chk_one_wait: assert property (@(posedge clk) disable iff (!rst_b)
        ((read || write) && !ack) |-> waitrequest ##1 !waitrequest)
        else $error("wait state count wrong");

    ////////////////////////////////////////////////////////////////////
    // register and source checks

    // the hold bit takes the written value at the write edge
    chk_hold_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_gtc |=> (timer_sync_hold == $past(writedata[GTC_HOLD_BIT])))
        else $error("hold bit did not take the written value");

    // both select fields take the written value at the write edge
    chk_csel_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_csel |=> ((csel[0] == $past(writedata[CSEL0_LSB +: CSEL_W]))
            && (csel[1] == $past(writedata[CSEL1_LSB +: CSEL_W]))))
        else $error("clock select field did not take the written value");

    // a write with the low byte disabled changes no register
    chk_be_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        (write && ack && !byteenable[0])
        |=> ($stable(timer_sync_hold) && $stable(csel[0]) && $stable(csel[1])))
        else $error("write without byte enable changed a register");

    // the divider steps by one whenever no prescaler reset is applied
    chk_div_step: assert property (@(posedge clk) disable iff (!rst_b)
        !sync_prescaler_reset |=> (div_cnt == DIV_W'($past(div_cnt) + 1'b1)))
        else $error("divider skipped or stalled");

    // no tap pulse at all while the prescaler reset is applied
    chk_halt_taps: assert property (@(posedge clk) disable iff (!rst_b)
        sync_prescaler_reset |-> (taps.tap == '0))
        else $error("tap pulse during prescaler reset");

    // every tap pulse lasts a single cycle
    chk_tap_width: assert property (@(posedge clk) disable iff (!rst_b)
        (taps.tap != '0) |=> (taps.tap == '0))
        else $error("tap pulse wider than one cycle");

    // the sync reset bit only rises from a control write
    chk_sync_rise: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(sync_prescaler_reset) |-> $past(wr_gtc))
        else $error("prescaler reset rose without a write");

    // the async reset bit only rises from a control write
    chk_async_rise: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(async_prescaler_reset) |-> $past(wr_gtc))
        else $error("async prescaler reset rose without a write");

    // unmapped words read back as zero
    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (read && !ack && address != GTC_IDX && address != CSEL_IDX
            && address != STAT_IDX) |=> (readdata == 32'h0000_0000))
        else $error("unmapped word read non-zero");

    // a control read shows the reset bit of the cycle it was taken
    chk_read_ctrl: assert property (@(posedge clk) disable iff (!rst_b)
        (read && !ack && address == GTC_IDX)
        |=> (readdata[GTC_SYNC_BIT] == $past(sync_prescaler_reset)))
        else $error("control read lost the prescaler reset bit");

    // a status read shows the halt level of the cycle it was taken
    chk_read_halt: assert property (@(posedge clk) disable iff (!rst_b)
        (read && !ack && address == STAT_IDX)
        |=> (readdata[STAT_HOLD_BIT] == $past(sync_prescaler_reset)))
        else $error("status read lost the halt bit");

    // the direct source of timer 0 stops under a prescaler reset
    chk_direct_halt0: assert property (@(posedge clk) disable iff (!rst_b)
        (csel[0] == CS_DIRECT && sync_prescaler_reset) |=> !timer_count_clock[0])
        else $error("timer 0 counted during prescaler reset");

    // the direct source of timer 1 stops under a prescaler reset
    chk_direct_halt1: assert property (@(posedge clk) disable iff (!rst_b)
        (csel[1] == CS_DIRECT && sync_prescaler_reset) |=> !timer_count_clock[1])
        else $error("timer 1 counted during prescaler reset");

    // main scenarios reached
    cov_hold_cycle: cover property (@(posedge clk) disable iff (!rst_b)
        timer_sync_hold ##[1:20] !timer_sync_hold);
    cov_both_timers: cover property (@(posedge clk) disable iff (!rst_b)
        timer_count_clock[0] && timer_count_clock[1]);
    cov_tap1024: cover property (@(posedge clk) disable iff (!rst_b)
        taps.tap[3]);

endmodule
`default_nettype wire

// [verification/stp_timer_units.sv]
// stp_timer_units: two timer counters fed by the prescaler count enables
// assumes one-cycle count enables and the prescaler reset level on clk
`timescale 1ns/1ps
`default_nettype none
module stp_timer_units
    import stp_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // count enables, prescaler reset level, count clear
    input  wire logic [NTIMER-1:0] tick,
    input  wire logic              psr,
    input  wire logic              clr,
    // counts, and cycles from prescaler reset to first tick
    output logic      [15:0]       cnt   [NTIMER],
    output logic      [15:0]       first [NTIMER]
);
    logic [15:0] since;

    ////////////////////////////////////////////////////////////////////////
    // count ticks; stamp the first tick after each prescaler reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            since <= 16'h0000;
            cnt   <= '{default: 16'h0000};
            first <= '{default: 16'h0000};
        end
        else
        begin
            since <= psr ? 16'h0000 : since + 16'h0001;
            for (int i = 0; i < NTIMER; i++)
            begin
                if (clr)
                    cnt[i] <= 16'h0000;
                else if (tick[i])
                    cnt[i] <= cnt[i] + 16'h0001;
                if (psr)
                    first[i] <= 16'h0000;
                else if (tick[i] && first[i] == 16'h0000)
                    first[i] <= since + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/shared_timer_prescaler_bench.sv]
// shared_timer_prescaler_bench: self-checking bench of the shared prescaler
// assumes an avalon slave that drops waitrequest sooner or later
`timescale 1ns/1ps
`default_nettype none
module shared_timer_prescaler_bench;
    import stp_pkg::*;
    logic              clk, rst_b, read, write, clr, waitrequest;
    logic              timer_sync_hold, sync_prescaler_reset, async_prescaler_reset;
    logic [7:0]        address;
    logic [31:0]       writedata, readdata;
    logic [3:0]        byteenable;
    logic [NTIMER-1:0] ext_count_pin, timer_count_clock;
    logic [15:0]       cnt   [NTIMER];
    logic [15:0]       first [NTIMER];
    logic [31:0]       expq  [$];
    int                mismatches, check_count, seed, k, h;

    ////////////////////////////////////////////////////////////////////////
    // clock, design and timer model
    initial clk = 1'b0;
    always #20 clk = ~clk;

    stp_shared_prescaler dut_u (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .ext_count_pin(ext_count_pin),
        .timer_count_clock(timer_count_clock), .timer_sync_hold(timer_sync_hold),
        .sync_prescaler_reset(sync_prescaler_reset),
        .async_prescaler_reset(async_prescaler_reset));

    stp_timer_units units_u (.clk(clk), .rst_b(rst_b), .tick(timer_count_clock),
        .psr(sync_prescaler_reset), .clr(clr), .cnt(cnt), .first(first));

    ////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one avalon access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        address    <= a;
        read       <= rd;
        write      <= ~rd;
        writedata  <= d;
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        // answer edge: the write lands and read data stand here
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        bus(1'b1, a, 32'h00000000, 4'hF);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'h1);
    endtask

    // clear the model counts for a fresh window
    task automatic tclr();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask

    // ticks expected in a 1024-cycle window per select code
    function automatic logic [15:0] taps(input int c);
        case (c)
            0:       taps = 16'h0000;
            1:       taps = 16'h0400;
            2:       taps = 16'h0080;
            3:       taps = 16'h0010;
            4:       taps = 16'h0004;
            default: taps = 16'h0001;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // read monitor: oldest note against the data at the answer edge
    always @(posedge clk)
        if (read === 1'b1 && waitrequest === 1'b0 && expq.size() > 0)
            check(readdata, expq.pop_front());

    // watchdog
    initial
    begin
        repeat (50000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        seed = 66217;
        mismatches = 0;
        check_count = 0;
        rst_b = 1'b0;
        {read, write, clr} = 3'h0;
        address = 8'h00;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        ext_count_pin = 2'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // reset values, unmapped index
        rd(GTC_IDX, 32'h00000000);
        rd(CSEL_IDX, 32'h00000000);
        rd(8'h10, 32'h00000000);
        // hold mode keeps both resets and halts direct counting
        wr(CSEL_IDX, 32'h00000011);
        wr(GTC_IDX, 32'h000000FF);
        rd(GTC_IDX, 32'h00000083);
        rd(STAT_IDX, 32'h00010000);
        bus(1'b0, GTC_IDX, 32'h00000001, 4'h0);
        rd(GTC_IDX, 32'h00000083);
        tclr();
        repeat (20) @(posedge clk);
        @(negedge clk);
        check({30'h0, timer_sync_hold, async_prescaler_reset}, 32'h00000003);
        check({16'h0000, cnt[0]}, 32'h00000000);
        wr(GTC_IDX, 32'h00000000);
        @(negedge clk);
        check({31'h0, sync_prescaler_reset}, 32'h00000000);
        tclr();
        repeat (30) @(posedge clk);
        @(negedge clk);
        check({cnt[1], cnt[0]}, 32'h001E001E);
        // every internal code on both timers, different taps at once
        for (k = 0; k < 6; k++)
        begin
            wr(CSEL_IDX, {25'h0, 3'(5 - k), 1'b0, 3'(k)});
            tclr();
            repeat (1024) @(posedge clk);
            @(negedge clk);
            check({16'h0000, cnt[0]}, {16'h0000, taps(k)});
            check({16'h0000, cnt[1]}, {16'h0000, taps(5 - k)});
        end
        // divider reset restarts both prescaled periods
        wr(CSEL_IDX, 32'h00000032);
        wr(GTC_IDX, 32'h00000001);
        @(negedge clk);
        check({31'h0, sync_prescaler_reset}, 32'h00000001);
        @(negedge clk);
        check({31'h0, sync_prescaler_reset}, 32'h00000000);
        repeat (80) @(posedge clk);
        @(negedge clk);
        check({31'h0, first[0] >= 16'h0001 && first[0] <= 16'h0009}, 32'h1);
        check({16'h0000, first[1] - first[0]}, 32'h00000038);
        // external edges: timer0 rising, timer1 falling, switched with pin stable
        wr(CSEL_IDX, {25'h0, CS_EXT_FALL, 1'b0, CS_EXT_RISE});
        repeat (4) @(posedge clk);
        tclr();
        @(posedge clk);
        ext_count_pin <= 2'h3;
        h = 0;
        do
        begin
            @(posedge clk);
            h++;
        end
        while (timer_count_clock[0] !== 1'b1 && h < 10);
        check(32'(h), 32'h00000003);
        // random legal half periods of 2 to 5 cycles
        for (k = 0; k < 5; k++)
        begin
            h = 2 + ({$random(seed)} % 4);
            ext_count_pin <= 2'h0;
            repeat (h) @(posedge clk);
            ext_count_pin <= 2'h3;
            repeat (h) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        check({cnt[1], cnt[0]}, 32'h00050006);
        report_and_stop();
    end
endmodule
`default_nettype wire
